// ===== core/mse_monitor.sv
// Function
// - three states quiet, watching, reporting; reset puts the monitor in quiet.
// - in quiet memories keep indications locally; nothing reaches status or interrupt.
// - upsets found on read; single-bit is correctable, multibit is not.
// - while watching, any indication from an enabled memory sets the present flag and raises the interrupt.
// - entering reporting holds one indication and its memory index.
// - three separate status bits show quiet, reporting and watching.
// - advance request steps states; it stays set until the next state is reached.
// - busy is high for the whole transition, which spans several cycles.
// - first advance after reset clears all detection logic and goes quiet to watching.
// - readout steps watching to quiet, then advances until watching again.
// - each memory holds one indication, cleared once the monitor reads it.
// - an indication is four flags plus one address.
// - uncorrectable sets its flag and address, else its overflow flag.
// - correctable sets its flag and address, else its overflow flag.
// - uncorrectable information wins over correctable.
// - addresses are captured only while watching.
// - interrupt appears at bit 20 of the system interrupt source vector.
// - device reset leaves stored memory contents unchanged.
module mse_monitor (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // software control
  input wire logic advance_request,
  input wire logic [mse_pkg::DIV_W-1:0] monitor_speed_divider,
  input wire logic host_link_mac_monitor_enable,
  // memory read side
  input wire logic [mse_pkg::NUM_MEM-1:0] mem_read_valid,
  input wire logic [mse_pkg::NUM_MEM-1:0] mem_single_err,
  input wire logic [mse_pkg::NUM_MEM-1:0] mem_multi_err,
  input wire logic [mse_pkg::NUM_MEM*mse_pkg::ADDR_W-1:0] mem_read_addr,
  // monitor status
  output logic state_quiet,
  output logic in_watch_flag,
  output logic state_report,
  output logic busy,
  output logic advance_pending,
  output logic indication_present,
  output logic integrity_interrupt,
  output logic [mse_pkg::INTR_SOURCES-1:0] interrupt_sources,
  // reported indication
  output logic uncorrectable_flag,
  output logic uncorrectable_overflow_flag,
  output logic correctable_flag,
  output logic correctable_overflow_flag,
  output logic [mse_pkg::ADDR_W-1:0] indication_address,
  output logic [mse_pkg::IDX_W-1:0] indication_memory_index
);

  function automatic logic [mse_pkg::IDX_W-1:0] first_index(
    input logic [mse_pkg::NUM_MEM-1:0] vec
  );
    logic [mse_pkg::IDX_W-1:0] idx;
    idx = mse_pkg::IDX_RESET;
    for (int i = mse_pkg::NUM_MEM - 1; i >= 0; i--) begin
      if (vec[i]) begin
        idx = mse_pkg::IDX_W'(i);
      end
    end
    return idx;
  endfunction : first_index

  // slot state
  logic [mse_pkg::NUM_MEM-1:0] slot_has;
  logic [mse_pkg::NUM_MEM-1:0] slot_uncorr;
  logic [mse_pkg::NUM_MEM-1:0] slot_uncorr_ovf;
  logic [mse_pkg::NUM_MEM-1:0] slot_corr;
  logic [mse_pkg::NUM_MEM-1:0] slot_corr_ovf;
  logic [mse_pkg::ADDR_W-1:0] slot_addr [mse_pkg::NUM_MEM];
  logic [mse_pkg::NUM_MEM-1:0] enable_mask;
  logic [mse_pkg::NUM_MEM-1:0] masked;
  logic [mse_pkg::IDX_W-1:0] first_sel;

  // divider
  logic [mse_pkg::DIV_W-1:0] div_cnt;
  logic [mse_pkg::DIV_W-1:0] next_div_cnt;
  logic tick;

  // sequencer
  mse_pkg::mse_state_type state;
  mse_pkg::mse_state_type next_state;
  logic pending;
  logic next_pending;
  logic [mse_pkg::TCNT_W-1:0] tcnt;
  logic [mse_pkg::TCNT_W-1:0] next_tcnt;
  logic first_done;
  logic next_first_done;
  logic clear_det;
  logic next_clear_det;
  logic [mse_pkg::NUM_MEM-1:0] read_out;
  logic [mse_pkg::NUM_MEM-1:0] next_read_out;
  logic next_state_quiet;
  logic next_in_watch_flag;
  logic next_state_report;
  logic next_indication_present;
  logic [mse_pkg::INTR_SOURCES-1:0] next_interrupt_sources;
  logic next_uncorrectable_flag;
  logic next_uncorrectable_overflow_flag;
  logic next_correctable_flag;
  logic next_correctable_overflow_flag;
  logic [mse_pkg::ADDR_W-1:0] next_indication_address;
  logic [mse_pkg::IDX_W-1:0] next_indication_memory_index;

  // per-memory detection logic
  for (genvar g = 0; g < mse_pkg::NUM_MEM; g++) begin : g_slot
    mse_mem_slot u_slot (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .read_valid(mem_read_valid[g]),
      .single_err(mem_single_err[g]),
      .multi_err(mem_multi_err[g]),
      .read_addr(mem_read_addr[g*mse_pkg::ADDR_W +: mse_pkg::ADDR_W]),
      .watching(in_watch_flag),
      .clear_det(clear_det),
      .read_out(read_out[g]),
      .has_ind(slot_has[g]),
      .uncorr(slot_uncorr[g]),
      .uncorr_ovf(slot_uncorr_ovf[g]),
      .corr(slot_corr[g]),
      .corr_ovf(slot_corr_ovf[g]),
      .addr(slot_addr[g])
    );
  end

  // the host-link memory is bypassed unless enabled
  always_comb begin
    enable_mask = '1;
    enable_mask[mse_pkg::HOST_LINK_MEM] = host_link_mac_monitor_enable;
  end

  assign masked = slot_has & enable_mask;
  assign first_sel = first_index(masked);

  // speed divider
  always_comb begin
    tick = (div_cnt >= monitor_speed_divider);
    next_div_cnt = tick ? mse_pkg::DIV_CNT_RESET : div_cnt + 8'h01;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_cnt <= mse_pkg::DIV_CNT_RESET;
    end else if (clk_en) begin
      div_cnt <= next_div_cnt;
    end
  end

  // state sequencer
  always_comb begin
    next_state = state;
    next_pending = pending;
    next_tcnt = tcnt;
    next_first_done = first_done;
    next_clear_det = 1'b0;
    next_read_out = '0;
    next_indication_present = indication_present;
    next_uncorrectable_flag = uncorrectable_flag;
    next_uncorrectable_overflow_flag = uncorrectable_overflow_flag;
    next_correctable_flag = correctable_flag;
    next_correctable_overflow_flag = correctable_overflow_flag;
    next_indication_address = indication_address;
    next_indication_memory_index = indication_memory_index;
    if (!pending) begin
      if (advance_request) begin
        next_pending = 1'b1;
        next_tcnt = mse_pkg::TCNT_RESET;
      end
    end else if (tick) begin
      if (tcnt != mse_pkg::TRANSIT_LAST) begin
        next_tcnt = tcnt + 2'h1;
      end else begin
        next_pending = 1'b0;
        case (state)
          mse_pkg::MON_WATCH: begin
            next_state = mse_pkg::MON_QUIET;
          end
          default: begin
            if (state == mse_pkg::MON_QUIET && !first_done) begin
              next_first_done = 1'b1;
              next_clear_det = 1'b1;
              next_indication_present = 1'b0;
              next_state = mse_pkg::MON_WATCH;
            end else if (|masked) begin
              next_uncorrectable_flag = slot_uncorr[first_sel];
              next_uncorrectable_overflow_flag = slot_uncorr_ovf[first_sel];
              next_correctable_flag = slot_corr[first_sel];
              next_correctable_overflow_flag = slot_corr_ovf[first_sel];
              next_indication_address = slot_addr[first_sel];
              next_indication_memory_index = first_sel;
              next_read_out[first_sel] = 1'b1;
              next_state = mse_pkg::MON_REPORT;
            end else begin
              next_indication_present = 1'b0;
              next_state = mse_pkg::MON_WATCH;
            end
          end
        endcase
      end
    end
    if (state == mse_pkg::MON_WATCH && !clear_det && |masked) begin
      next_indication_present = 1'b1;
    end
    next_state_quiet = (next_state == mse_pkg::MON_QUIET);
    next_in_watch_flag = (next_state == mse_pkg::MON_WATCH);
    next_state_report = (next_state == mse_pkg::MON_REPORT);
    next_interrupt_sources = '0;
    next_interrupt_sources[mse_pkg::INTR_BIT] = next_indication_present;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= mse_pkg::MON_QUIET;
      pending <= 1'b0;
      tcnt <= mse_pkg::TCNT_RESET;
      first_done <= 1'b0;
      clear_det <= 1'b0;
      read_out <= '0;
      state_quiet <= 1'b1;
      in_watch_flag <= 1'b0;
      state_report <= 1'b0;
      busy <= 1'b0;
      advance_pending <= 1'b0;
      indication_present <= 1'b0;
      integrity_interrupt <= 1'b0;
      interrupt_sources <= '0;
      uncorrectable_flag <= 1'b0;
      uncorrectable_overflow_flag <= 1'b0;
      correctable_flag <= 1'b0;
      correctable_overflow_flag <= 1'b0;
      indication_address <= mse_pkg::ADDR_RESET;
      indication_memory_index <= mse_pkg::IDX_RESET;
    end else if (clk_en) begin
      state <= next_state;
      pending <= next_pending;
      tcnt <= next_tcnt;
      first_done <= next_first_done;
      clear_det <= next_clear_det;
      read_out <= next_read_out;
      state_quiet <= next_state_quiet;
      in_watch_flag <= next_in_watch_flag;
      state_report <= next_state_report;
      busy <= next_pending;
      advance_pending <= next_pending;
      indication_present <= next_indication_present;
      integrity_interrupt <= next_indication_present;
      interrupt_sources <= next_interrupt_sources;
      uncorrectable_flag <= next_uncorrectable_flag;
      uncorrectable_overflow_flag <= next_uncorrectable_overflow_flag;
      correctable_flag <= next_correctable_flag;
      correctable_overflow_flag <= next_correctable_overflow_flag;
      indication_address <= next_indication_address;
      indication_memory_index <= next_indication_memory_index;
    end
  end

  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  AST_ONE_STATE: assert property (
    $onehot({state_quiet, in_watch_flag, state_report}))
    else $error("state bits not one-hot");
  AST_BUSY_IS_PENDING: assert property (
    busy == advance_pending)
    else $error("busy and pending disagree");
  AST_REQ_HELD: assert property (
    $changed({state_quiet, in_watch_flag, state_report}) |-> $past(advance_pending) && !advance_pending)
    else $error("state moved without a held request");
  AST_BUSY_SPANS: assert property (
    $rose(busy) |=> busy)
    else $error("transition shorter than two cycles");
  AST_IND_ONLY_WATCH: assert property (
    $rose(indication_present) |-> $past(in_watch_flag))
    else $error("indication flag set outside watching");
  AST_IRQ_BIT: assert property (
    interrupt_sources[mse_pkg::INTR_BIT] == integrity_interrupt && $onehot0(interrupt_sources)
    && integrity_interrupt == indication_present)
    else $error("interrupt not at its source bit");
  AST_REPORT_HOLDS: assert property (
    $fell(busy) && state_report |-> uncorrectable_flag || uncorrectable_overflow_flag
    || correctable_flag || correctable_overflow_flag)
    else $error("reporting without an indication");
  AST_FIRST_ADVANCE: assert property (
    $fell(busy) && $past(state_quiet) && !$past(first_done) |-> in_watch_flag && clear_det)
    else $error("first advance did not clear and watch");
  AST_WATCH_TO_QUIET: assert property (
    $fell(busy) && $past(in_watch_flag) |-> state_quiet)
    else $error("watching did not step to quiet");
  AST_EMPTY_TO_WATCH: assert property (
    $fell(busy) && !$past(in_watch_flag) && $past(first_done) && $past(masked) == '0
    |-> in_watch_flag && !indication_present)
    else $error("empty scan did not return to watching");

endmodule : mse_monitor

// ===== core/mse_pkg.sv
package mse_pkg;
  // memory slots watched by the monitor
  localparam int NUM_MEM = 4;
  localparam int IDX_W = 2;
  localparam int ADDR_W = 10;
  // slot index of the host-link mac memory
  localparam int HOST_LINK_MEM = 3;
  // speed divider
  localparam int DIV_W = 8;
  localparam logic [DIV_W-1:0] DIV_CNT_RESET = 8'h00;
  // divider ticks spent in each state transition
  localparam int TCNT_W = 2;
  localparam logic [TCNT_W-1:0] TRANSIT_TICKS = 2'h2;
  localparam logic [TCNT_W-1:0] TRANSIT_LAST = TRANSIT_TICKS - 2'h1;
  localparam logic [TCNT_W-1:0] TCNT_RESET = 2'h0;
  // system interrupt controller source vector
  localparam int INTR_SOURCES = 24;
  localparam int INTR_BIT = 20;
  // reset values of the reported indication
  localparam logic [ADDR_W-1:0] ADDR_RESET = 10'h000;
  localparam logic [IDX_W-1:0] IDX_RESET = 2'h0;

  typedef enum logic [1:0] {
    MON_QUIET,
    MON_WATCH,
    MON_REPORT
  } mse_state_type;
endpackage : mse_pkg

// ===== core/mse_mem_slot.sv
module mse_mem_slot (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // memory read side
  input wire logic read_valid,
  input wire logic single_err,
  input wire logic multi_err,
  input wire logic [mse_pkg::ADDR_W-1:0] read_addr,
  // monitor side
  input wire logic watching,
  input wire logic clear_det,
  input wire logic read_out,
  output logic has_ind,
  output logic uncorr,
  output logic uncorr_ovf,
  output logic corr,
  output logic corr_ovf,
  output logic [mse_pkg::ADDR_W-1:0] addr
);

  logic next_uncorr;
  logic next_uncorr_ovf;
  logic next_corr;
  logic next_corr_ovf;
  logic [mse_pkg::ADDR_W-1:0] next_addr;

  assign has_ind = uncorr | uncorr_ovf | corr | corr_ovf;

  // clear first, so an upset in the same cycle survives
  always_comb begin
    next_uncorr = uncorr;
    next_uncorr_ovf = uncorr_ovf;
    next_corr = corr;
    next_corr_ovf = corr_ovf;
    next_addr = addr;
    if (clear_det || read_out) begin
      next_uncorr = 1'b0;
      next_uncorr_ovf = 1'b0;
      next_corr = 1'b0;
      next_corr_ovf = 1'b0;
    end
    if (read_valid && multi_err) begin
      if (watching && !next_uncorr) begin
        next_uncorr = 1'b1;
        next_addr = read_addr;
        if (next_corr) begin
          next_corr = 1'b0;
          next_corr_ovf = 1'b1;
        end
      end else begin
        next_uncorr_ovf = 1'b1;
      end
    end else if (read_valid && single_err) begin
      if (watching && !next_uncorr && !next_corr) begin
        next_corr = 1'b1;
        next_addr = read_addr;
      end else begin
        next_corr_ovf = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      uncorr <= 1'b0;
      uncorr_ovf <= 1'b0;
      corr <= 1'b0;
      corr_ovf <= 1'b0;
    end else if (clk_en) begin
      uncorr <= next_uncorr;
      uncorr_ovf <= next_uncorr_ovf;
      corr <= next_corr;
      corr_ovf <= next_corr_ovf;
    end
  end

  // address store is left alone by reset
  always_ff @(posedge ref_clk) begin
    if (clk_en) begin
      addr <= next_addr;
    end
  end

  AST_UNCORR_OVER_CORR: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(uncorr) && $past(corr) && !$past(read_out) && !$past(clear_det) |-> !corr && corr_ovf)
    else $error("uncorrectable did not displace correctable");
  AST_ADDR_ONLY_WATCH: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ($rose(uncorr) || $rose(corr)) |-> $past(watching))
    else $error("address captured outside watching");
  AST_CLEAR_EMPTIES: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $past(read_out) && $past(clk_en) && !$past(read_valid) |-> !has_ind)
    else $error("indication not cleared by read out");

endmodule : mse_mem_slot

// ===== dv/mse_mem_model.sv
module mse_mem_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // read commands from the bench
  input wire logic rd_go,
  input wire logic [mse_pkg::IDX_W-1:0] rd_slot,
  input wire logic rd_multi,
  input wire logic rd_single,
  input wire logic [mse_pkg::ADDR_W-1:0] rd_addr,
  // memory read side
  output logic [mse_pkg::NUM_MEM-1:0] mem_read_valid,
  output logic [mse_pkg::NUM_MEM-1:0] mem_single_err,
  output logic [mse_pkg::NUM_MEM-1:0] mem_multi_err,
  output logic [mse_pkg::NUM_MEM*mse_pkg::ADDR_W-1:0] mem_read_addr
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle lines keep changing so stale values never look like a read
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_read_valid <= '0;
      mem_single_err <= '0;
      mem_multi_err <= '0;
      mem_read_addr <= '0;
    end else begin
      mem_read_valid <= '0;
      mem_single_err <= ~mem_single_err;
      mem_multi_err <= ~mem_multi_err;
      mem_read_addr <= ~mem_read_addr;
      if (rd_go) begin
        mem_read_valid[rd_slot] <= 1'b1;
        mem_single_err[rd_slot] <= rd_single;
        mem_multi_err[rd_slot] <= rd_multi;
        mem_read_addr[rd_slot*mse_pkg::ADDR_W +: mse_pkg::ADDR_W] <= rd_addr;
      end
    end
  end
endmodule : mse_mem_model

// ===== dv/mse_monitor_tb.sv
module mse_monitor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic advance_request = 1'b0;
  logic [mse_pkg::DIV_W-1:0] monitor_speed_divider = 8'h00;
  logic host_link_mac_monitor_enable = 1'b0;
  logic rd_go = 1'b0;
  logic [mse_pkg::IDX_W-1:0] rd_slot = 2'h0;
  logic rd_multi = 1'b0;
  logic rd_single = 1'b0;
  logic [mse_pkg::ADDR_W-1:0] rd_addr = 10'h000;
  logic [mse_pkg::NUM_MEM-1:0] mem_read_valid, mem_single_err, mem_multi_err;
  logic [mse_pkg::NUM_MEM*mse_pkg::ADDR_W-1:0] mem_read_addr;
  logic state_quiet, in_watch_flag, state_report, busy, advance_pending;
  logic indication_present, integrity_interrupt;
  logic [mse_pkg::INTR_SOURCES-1:0] interrupt_sources;
  logic uncorrectable_flag, uncorrectable_overflow_flag, correctable_flag;
  logic correctable_overflow_flag;
  logic [mse_pkg::ADDR_W-1:0] indication_address;
  logic [mse_pkg::IDX_W-1:0] indication_memory_index;
  logic [2:0] st;
  logic [3:0] fl;
  int n_mismatch = 0;
  int samples_checked = 0;

  assign st = {state_quiet, in_watch_flag, state_report};
  assign fl = {uncorrectable_flag, uncorrectable_overflow_flag, correctable_flag,
    correctable_overflow_flag};

  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  mse_mem_model i_mem (.ref_clk, .reset_n, .rd_go, .rd_slot, .rd_multi, .rd_single,
    .rd_addr, .mem_read_valid, .mem_single_err, .mem_multi_err, .mem_read_addr);

  mse_monitor i_dut (.ref_clk, .reset_n, .clk_en, .advance_request, .monitor_speed_divider,
    .host_link_mac_monitor_enable, .mem_read_valid, .mem_single_err, .mem_multi_err,
    .mem_read_addr, .state_quiet, .in_watch_flag, .state_report, .busy, .advance_pending,
    .indication_present, .integrity_interrupt, .interrupt_sources, .uncorrectable_flag,
    .uncorrectable_overflow_flag, .correctable_flag, .correctable_overflow_flag,
    .indication_address, .indication_memory_index);

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  // one read on one memory, then time for the flag to travel
  task automatic mem_rd(input logic [1:0] s, input logic m, input logic sg,
      input logic [9:0] a);
    @(posedge ref_clk);
    rd_go <= 1'b1;
    rd_slot <= s;
    rd_multi <= m;
    rd_single <= sg;
    rd_addr <= a;
    @(posedge ref_clk);
    rd_go <= 1'b0;
    tick(4);
  endtask : mem_rd

  // one advance request, held until busy shows, then the new state
  task automatic step(input logic [2:0] exp_st);
    int n;
    int d;
    @(posedge ref_clk);
    advance_request <= 1'b1;
    n = 0;
    while (busy !== 1'b1 && n < 8) begin
      tick(1);
      n++;
    end
    if (busy !== 1'b1) begin
      n_mismatch++;
      give_verdict();
    end
    d = int'(monitor_speed_divider);
    n = 0;
    while (busy === 1'b1 && n < 40) begin
      chk("advance_pending", 1, advance_pending);
      n++;
      @(posedge ref_clk);
      advance_request <= 1'b0;
      #1;
    end
    if (busy === 1'b1) begin
      n_mismatch++;
      give_verdict();
    end
    chk("busy_length_ok", 1, (n >= d + 2 && n <= 2 * d + 3));
    chk("state", exp_st, st);
  endtask : step

  task automatic chk_rep(input logic [3:0] f, input logic [9:0] a, input logic [1:0] ix);
    chk("report_flags", {f, ix}, {fl, indication_memory_index});
    chk("index_handled", 1, int'(indication_memory_index) < mse_pkg::NUM_MEM);
    if (f[3] | f[1]) begin
      chk("report_address", a, indication_address);
    end
  endtask : chk_rep

  initial begin
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    tick(1);
    chk("state", 3'b100, st);
    chk("idle_outputs", 0, {busy, indication_present, interrupt_sources});
    mem_rd(2'h1, 1'b0, 1'b1, 10'h011);
    chk("present", 0, {indication_present, integrity_interrupt});
    @(posedge ref_clk);
    monitor_speed_divider <= 8'h03;
    step(3'b010);
    chk("present", 0, indication_present);
    @(posedge ref_clk);
    monitor_speed_divider <= 8'h00;
    mem_rd(2'h3, 1'b1, 1'b0, 10'h3FF);
    chk("present", 0, indication_present);
    mem_rd(2'h1, 1'b1, 1'b1, 10'h155);
    chk("interrupt_sources", 24'h100000, interrupt_sources);
    chk("present", 3, {indication_present, integrity_interrupt});
    mem_rd(2'h0, 1'b0, 1'b1, 10'h033);
    mem_rd(2'h0, 1'b1, 1'b0, 10'h022);
    mem_rd(2'h2, 1'b0, 1'b1, 10'h0AA);
    mem_rd(2'h2, 1'b0, 1'b1, 10'h0BB);
    step(3'b100);
    step(3'b001);
    chk_rep(4'b1001, 10'h022, 2'h0);
    step(3'b001);
    chk_rep(4'b1000, 10'h155, 2'h1);
    step(3'b001);
    chk_rep(4'b0011, 10'h0AA, 2'h2);
    step(3'b010);
    chk("present", 0, indication_present);
    step(3'b100);
    mem_rd(2'h2, 1'b0, 1'b1, 10'h0CC);
    mem_rd(2'h1, 1'b1, 1'b0, 10'h0DD);
    chk("present", 0, indication_present);
    @(posedge ref_clk);
    host_link_mac_monitor_enable <= 1'b1;
    step(3'b001);
    chk_rep(4'b0100, 10'h000, 2'h1);
    step(3'b001);
    chk_rep(4'b0001, 10'h000, 2'h2);
    step(3'b001);
    chk_rep(4'b1000, 10'h3FF, 2'h3);
    step(3'b010);
    step(3'b100);
    step(3'b010);
    @(posedge ref_clk);
    clk_en <= 1'b0;
    mem_rd(2'h0, 1'b1, 1'b0, 10'h2AB);
    chk("frozen_present", 0, indication_present);
    @(posedge ref_clk);
    clk_en <= 1'b1;
    mem_rd(2'h0, 1'b1, 1'b0, 10'h2AB);
    chk("present", 1, indication_present);
    @(posedge ref_clk);
    reset_n <= 1'b0;
    tick(2);
    chk("reset_state", 3'b100, st);
    chk("reset_outputs", 0, {busy, indication_present, interrupt_sources});
    @(posedge ref_clk);
    reset_n <= 1'b1;
    step(3'b010);
    step(3'b100);
    step(3'b010);
    give_verdict();
  end
endmodule : mse_monitor_tb
